/* rtl/adc_conversion_control.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control
   import adc_conv_pkg::*;
(
   // system
   input  wire logic              CLK,
   input  wire logic              ARST_N,
   input  wire logic              CE,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic [31:0]            PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // power state
   input  wire logic              STOP_MODE,
   // analog front end
   input  wire logic              COMP_IN,
   output logic [RES_W-1:0]       DAC_CODE,
   output logic                   SAMPLE_HOLD,
   output logic [CHAN_W-1:0]      CHAN_MUX,
   output logic                   BANDGAP_EN,
   output logic [1:0]             PTB_ANALOG,
   output logic                   CONV_BUSY,
   // port b digital path
   input  wire logic [1:0]        PORT_B_IN,
   output logic [1:0]             PORT_B_DIGITAL
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   logic              pready_reg;
   logic [CHAN_W-1:0] chan_reg;
   logic              complete_reg;
   logic              complete_next;
   logic              clk_src_reg;
   logic              mode8_reg;
   logic              long_reg;
   logic              async_en_reg;
   logic [2:0]        div_reg;
   logic [2:0]        div_next;

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   logic        acc_setup;
   logic        acc_done;
   logic        hit_status;
   logic        hit_clock;
   logic        hit_res_hi;
   logic        hit_res_lo;
   logic        mapped;
   logic        wr_status;
   logic        wr_clock;
   logic        rd_res_lo;
   logic [31:0] status_rd;
   logic [31:0] clock_rd;
   logic [31:0] res_hi_rd;
   logic [31:0] res_lo_rd;
   logic [31:0] rd_value;

   assign acc_setup  = PSEL & PENABLE & ~pready_reg;
   assign acc_done   = PSEL & PENABLE & pready_reg;
   assign hit_status = PADDR == OFS_STATUS;
   assign hit_clock  = PADDR == OFS_CLOCK;
   assign hit_res_hi = PADDR == OFS_RES_HI;
   assign hit_res_lo = PADDR == OFS_RES_LO;
   assign mapped     = hit_status | hit_clock | hit_res_hi | hit_res_lo;
   assign wr_status  = acc_done & PWRITE & hit_status;
   assign wr_clock   = acc_done & PWRITE & hit_clock;
   assign rd_res_lo  = acc_done & ~PWRITE & hit_res_lo;

   logic [RES_W-1:0] result;
   logic             done;
   logic             busy;

   assign status_rd = {24'h0, complete_reg, 2'b00, chan_reg};
   assign clock_rd  = {24'h0, async_en_reg, 2'b00, long_reg, 2'b00, mode8_reg, clk_src_reg};
   assign res_hi_rd = {30'h0, result[RES_W-1:8]};
   assign res_lo_rd = {24'h0, result[7:0]};
   assign rd_value  = hit_status ? status_rd :
                      hit_clock  ? clock_rd  :
                      hit_res_hi ? res_hi_rd :
                      hit_res_lo ? res_lo_rd : 32'h0;

   // one wait state: data and ready are set together, commit on next edge
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pready_reg <= 1'b0;
         PREADY     <= 1'b0;
         PRDATA     <= 32'h0;
         PSLVERR    <= 1'b0;
      end else if (CE) begin
         pready_reg <= acc_setup;
         PREADY     <= acc_setup;
         PSLVERR    <= acc_setup & ~mapped;
         if (acc_setup) begin
            PRDATA <= PWRITE ? 32'h0 : rd_value;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control and status
   logic start_conv;
   logic stop_conv;

   assign start_conv    = wr_status & (PWDATA[CHAN_W-1:0] != CHAN_OFF);
   assign stop_conv     = wr_status & (PWDATA[CHAN_W-1:0] == CHAN_OFF);
   // a finishing conversion beats a clear in the same cycle
   assign complete_next = done ? 1'b1 : ((wr_status | rd_res_lo) ? 1'b0 : complete_reg);

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         chan_reg     <= RST_CHAN;
         complete_reg <= 1'b0;
         clk_src_reg  <= 1'b0;
         mode8_reg    <= 1'b0;
         long_reg     <= 1'b0;
         async_en_reg <= 1'b0;
      end else if (CE) begin
         complete_reg <= complete_next;
         if (wr_status) begin
            chan_reg <= PWDATA[CHAN_W-1:0];
         end
         if (wr_clock) begin
            clk_src_reg  <= PWDATA[BIT_CLK_SRC];
            mode8_reg    <= PWDATA[BIT_MODE8];
            long_reg     <= PWDATA[BIT_LONG_SMP];
            async_en_reg <= PWDATA[BIT_ASYNC_EN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion clock selection
   logic use_async;
   logic osc_run;
   logic async_tick;
   logic tick;

   assign use_async  = clk_src_reg | async_en_reg;
   // the oscillator only survives stop when explicitly enabled
   assign osc_run    = use_async & (~STOP_MODE | async_en_reg);
   assign async_tick = osc_run & (div_reg == ASYNC_DIV_LAST);
   // bus x4 stops with the core clocks in stop mode
   assign tick       = use_async ? async_tick : ~STOP_MODE;
   assign div_next   = (!osc_run || async_tick) ? 3'h0 : div_reg + 3'h1;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         div_reg <= 3'h0;
      end else if (CE) begin
         div_reg <= div_next;
      end
   end

   sar_engine u_sar (
      .clk         (CLK),
      .arst_n      (ARST_N),
      .ce          (CE),
      .tick        (tick),
      .start       (start_conv),
      .abort       (stop_conv),
      .long_sample (long_reg),
      .mode8       (mode8_reg),
      .comp_in     (COMP_IN),
      .dac_code    (DAC_CODE),
      .sampling    (SAMPLE_HOLD),
      .busy        (busy),
      .done        (done),
      .result      (result)
   );

   ////////////////////////////////////////////////////////////////////////
   // analog mux and port b
   logic [1:0] ptb_sel;

   assign ptb_sel = {chan_reg == CHAN_PORT_B_BIT_ONE, chan_reg == CHAN_PORT_B_BIT_ZERO};

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CHAN_MUX       <= RST_CHAN;
         BANDGAP_EN     <= 1'b0;
         PTB_ANALOG     <= 2'b00;
         CONV_BUSY      <= 1'b0;
         PORT_B_DIGITAL <= 2'b00;
      end else if (CE) begin
         CHAN_MUX       <= chan_reg;
         BANDGAP_EN     <= chan_reg == CHAN_BANDGAP;
         PTB_ANALOG     <= ptb_sel;
         CONV_BUSY      <= busy;
         // digital path never gated by analog selection
         PORT_B_DIGITAL <= PORT_B_IN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   res_hi_read_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      (CE && acc_setup && !PWRITE && hit_res_hi && !done)
      |=> (PRDATA == {30'h0, result[RES_W-1:8]}))
      else $error("high result read wrong");

   bus_clk_tick_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      (!use_async && !STOP_MODE) |-> tick)
      else $error("bus x4 clock not used");

   async_src_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      async_en_reg |-> (tick == async_tick))
      else $error("async enable does not select async source");

   stop_run_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      (CE && STOP_MODE && async_en_reg && busy) |-> ##[0:5] tick)
      else $error("conversion clock stalled in stop mode");

   stop_halt_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      (STOP_MODE && !async_en_reg) |-> !tick)
      else $error("conversion clocked in stop without async enable");

   chan_mux_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      (CE && wr_status) ##1 CE |=> (CHAN_MUX == $past(PWDATA[CHAN_W-1:0], 2)))
      else $error("channel mux not following channel select");

   ptb_map_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      PTB_ANALOG == {CHAN_MUX == CHAN_PORT_B_BIT_ONE, CHAN_MUX == CHAN_PORT_B_BIT_ZERO})
      else $error("port b analog taps mismatch channel");

   dig_path_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      (CE && PTB_ANALOG != 2'b00) |=> (PORT_B_DIGITAL == $past(PORT_B_IN)))
      else $error("digital path lost under analog selection");

   done_flag_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      (CE && done) |=> complete_reg)
      else $error("completion flag not set");

   cov_stop_conv_c: cover property (@(posedge CLK) disable iff (!ARST_N)
      done && STOP_MODE && async_en_reg);
   cov_bandgap_c: cover property (@(posedge CLK) disable iff (!ARST_N)
      done && BANDGAP_EN);
endmodule
`default_nettype wire

/* rtl/adc_conv_pkg.sv */
package adc_conv_pkg;
   ////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [11:0] OFS_STATUS = 12'h000;
   localparam logic [11:0] OFS_CLOCK  = 12'h004;
   localparam logic [11:0] OFS_RES_HI = 12'h008;
   localparam logic [11:0] OFS_RES_LO = 12'h00c;
   ////////////////////////////////////////////////////////////////////////
   // field positions and widths
   localparam int BIT_COMPLETE   = 7;
   localparam int BIT_CLK_SRC    = 0;
   localparam int BIT_MODE8      = 1;
   localparam int BIT_LONG_SMP   = 4;
   localparam int BIT_ASYNC_EN   = 7;
   localparam int CHAN_W         = 5;
   localparam int RES_W          = 10;
   ////////////////////////////////////////////////////////////////////////
   // channel codes
   localparam logic [4:0] CHAN_PORT_B_BIT_ZERO    = 5'h04;
   localparam logic [4:0] CHAN_PORT_B_BIT_ONE    = 5'h05;
   localparam logic [4:0] CHAN_BANDGAP = 5'h1e;
   localparam logic [4:0] CHAN_OFF     = 5'h1f;
   ////////////////////////////////////////////////////////////////////////
   // reset values and timing counts
   localparam logic [4:0] RST_CHAN        = CHAN_OFF;
   localparam logic [3:0] SHORT_SAMPLE    = 4'h3;
   localparam logic [3:0] LONG_SAMPLE     = 4'hf;
   localparam logic [3:0] TOP_BIT_10      = 4'h9;
   localparam logic [3:0] TOP_BIT_8       = 4'h7;
   localparam logic [2:0] ASYNC_DIV_LAST  = 3'h4;
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SAMPLE  = 2'b01,
      ST_CONVERT = 2'b10
   } sar_state_t;
endpackage

/* rtl/sar_engine.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_engine
   import adc_conv_pkg::*;
(
   // system
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             ce,
   input  wire logic             tick,
   // control
   input  wire logic             start,
   input  wire logic             abort,
   input  wire logic             long_sample,
   input  wire logic             mode8,
   // analog
   input  wire logic             comp_in,
   output logic [RES_W-1:0]      dac_code,
   output logic                  sampling,
   // status
   output logic                  busy,
   output logic                  done,
   output logic [RES_W-1:0]      result
);
   sar_state_t       state_reg;
   logic [3:0]       cnt_reg;
   logic [3:0]       bit_reg;
   logic             mode8_reg;
   logic [RES_W-1:0] bit_mask;
   logic [RES_W-1:0] trial_kept;
   logic [3:0]       top_bit;

   assign bit_mask   = RES_W'(1) << bit_reg;
   // comparator high: input above trial level, keep the bit
   assign trial_kept = comp_in ? dac_code : (dac_code & ~bit_mask);
   assign top_bit    = mode8_reg ? TOP_BIT_8 : TOP_BIT_10;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 4'h0;
         bit_reg   <= 4'h0;
         mode8_reg <= 1'b0;
         dac_code  <= '0;
         sampling  <= 1'b0;
         busy      <= 1'b0;
         done      <= 1'b0;
         result    <= '0;
      end else if (ce) begin
         done <= 1'b0;
         if (start) begin
            // a new start restarts any conversion in flight
            state_reg <= ST_SAMPLE;
            cnt_reg   <= long_sample ? LONG_SAMPLE : SHORT_SAMPLE;
            mode8_reg <= mode8;
            sampling  <= 1'b1;
            busy      <= 1'b1;
         end else if (abort) begin
            state_reg <= ST_IDLE;
            sampling  <= 1'b0;
            busy      <= 1'b0;
         end else if (tick) begin
            case (state_reg)
               ST_SAMPLE: begin
                  if (cnt_reg == 4'h0) begin
                     state_reg <= ST_CONVERT;
                     sampling  <= 1'b0;
                     bit_reg   <= top_bit;
                     dac_code  <= RES_W'(1) << top_bit;
                  end else begin
                     cnt_reg <= cnt_reg - 4'h1;
                  end
               end
               ST_CONVERT: begin
                  if (bit_reg == 4'h0) begin
                     result    <= trial_kept;
                     done      <= 1'b1;
                     busy      <= 1'b0;
                     state_reg <= ST_IDLE;
                  end else begin
                     dac_code <= trial_kept | (bit_mask >> 1);
                     bit_reg  <= bit_reg - 4'h1;
                  end
               end
               ST_IDLE: begin
                  busy <= 1'b0;
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   top_bit_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && state_reg == ST_SAMPLE && tick && cnt_reg == 4'h0 && !start && !abort)
      |=> (bit_reg == ($past(mode8_reg) ? TOP_BIT_8 : TOP_BIT_10)))
      else $error("first trial bit does not match resolution");

   sample_len_a: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && start) |=> (cnt_reg == ($past(long_sample) ? LONG_SAMPLE : SHORT_SAMPLE)))
      else $error("sample count not loaded from long sample select");

   eight_bit_res_a: assert property (@(posedge clk) disable iff (!arst_n)
      (done && mode8_reg) |-> (result[RES_W-1:8] == 2'b00))
      else $error("8-bit result has upper bits set");

   cov_conv10_c: cover property (@(posedge clk) disable iff (!arst_n) done && !mode8_reg);
   cov_conv8_c:  cover property (@(posedge clk) disable iff (!arst_n) done && mode8_reg);
endmodule
`default_nettype wire

/* tb/test_adc_conversion_control.sv */
`timescale 1ns/10ps
`default_nettype none
module test_adc_conversion_control;
   import adc_conv_pkg::*;
   logic              CLK, ARST_N, CE, PSEL, PENABLE, PWRITE, STOP_MODE;
   logic [11:0]       PADDR;
   logic [31:0]       PWDATA, PRDATA;
   logic              PREADY, PSLVERR, COMP_IN, SAMPLE_HOLD, BANDGAP_EN, CONV_BUSY;
   logic [RES_W-1:0]  DAC_CODE, vin;
   logic [CHAN_W-1:0] CHAN_MUX;
   logic [1:0]        PTB_ANALOG, PORT_B_IN, PORT_B_DIGITAL;
   int                error_cnt, comparisons;
   logic [31:0]       q;
   logic              e;

   // comparator: analog level sits half a step above vin
   assign COMP_IN = (vin >= DAC_CODE);

   adc_conversion_control uut (
      .CLK(CLK), .ARST_N(ARST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .STOP_MODE(STOP_MODE),
      .COMP_IN(COMP_IN), .DAC_CODE(DAC_CODE), .SAMPLE_HOLD(SAMPLE_HOLD),
      .CHAN_MUX(CHAN_MUX), .BANDGAP_EN(BANDGAP_EN), .PTB_ANALOG(PTB_ANALOG),
      .CONV_BUSY(CONV_BUSY), .PORT_B_IN(PORT_B_IN), .PORT_B_DIGITAL(PORT_B_DIGITAL));

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic er);
      int n;
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1, "no pready");
      rq = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
      chk({31'h0, e}, 32'h0, "write error flag");
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0, q, e);
         n++;
      end while (q[BIT_COMPLETE] !== 1'b1 && n < 200);
      chk({31'h0, q[BIT_COMPLETE]}, 32'h1, "complete flag");
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk({27'h0, CHAN_MUX}, 32'h1f, "mux at reset");
      apb(1'b0, OFS_STATUS, 32'h0, q, e);
      chk(q, 32'h1f, "status at reset");
      apb(1'b0, 12'h010, 32'h0, q, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      chk(q, 32'h0, "unmapped data");
      wr(OFS_RES_LO, 32'hff);
      apb(1'b0, OFS_RES_LO, 32'h0, q, e);
      chk(q, 32'h0, "result is read-only");
   endtask

   // one conversion; sample length in cycles must land in [smin,smax]
   task automatic t_conv(input logic [7:0] cfg, input logic [4:0] ch,
                         input logic [9:0] v, input logic [31:0] hi,
                         input logic [31:0] lo, input int smin, input int smax);
      int n;
      vin <= v;
      wr(OFS_CLOCK, {24'h0, cfg});
      wr(OFS_STATUS, {27'h0, ch});
      n = 0;
      while (SAMPLE_HOLD !== 1'b1 && n < 8) begin
         @(posedge CLK);
         n++;
      end
      n = 0;
      while (SAMPLE_HOLD === 1'b1 && n < 100) begin
         @(posedge CLK);
         n++;
      end
      chk({31'h0, (n >= smin && n <= smax)}, 32'h1, "sample length");
      wait_done();
      apb(1'b0, OFS_RES_HI, 32'h0, q, e);
      chk(q, hi, "result high");
      apb(1'b0, OFS_RES_LO, 32'h0, q, e);
      chk(q, lo, "result low");
      apb(1'b0, OFS_STATUS, 32'h0, q, e);
      chk(q, {27'h0, ch}, "complete cleared by low read");
   endtask

   // in stop without the async enable no ticks come, so the conversion waits
   task automatic t_freeze();
      STOP_MODE <= 1'b1;
      vin <= 10'h155;
      wr(OFS_CLOCK, 32'h0);
      wr(OFS_STATUS, {27'h0, CHAN_PORT_B_BIT_ZERO});
      repeat (40) @(posedge CLK);
      chk({31'h0, CONV_BUSY}, 32'h1, "frozen busy");
      apb(1'b0, OFS_STATUS, 32'h0, q, e);
      chk({31'h0, q[BIT_COMPLETE]}, 32'h0, "frozen not done");
      STOP_MODE <= 1'b0;
      wait_done();
      STOP_MODE <= 1'b0;
   endtask

   task automatic t_chan();
      logic [4:0] codes [4];
      codes = '{CHAN_PORT_B_BIT_ZERO, CHAN_PORT_B_BIT_ONE, CHAN_BANDGAP, CHAN_OFF};
      foreach (codes[i]) begin
         wr(OFS_STATUS, {27'h0, codes[i]});
         repeat (3) @(posedge CLK);
         chk({27'h0, CHAN_MUX}, {27'h0, codes[i]}, "mux select");
         chk({30'h0, PTB_ANALOG}, {30'h0, codes[i] == CHAN_PORT_B_BIT_ONE,
             codes[i] == CHAN_PORT_B_BIT_ZERO}, "port b analog");
         chk({31'h0, BANDGAP_EN}, {31'h0, codes[i] == CHAN_BANDGAP}, "bandgap");
      end
      chk({31'h0, CONV_BUSY}, 32'h0, "off channel idles");
   endtask

   task automatic t_port();
      wr(OFS_STATUS, {27'h0, CHAN_PORT_B_BIT_ZERO});
      // pins stay inputs: only the bench drives them
      PORT_B_IN <= 2'b01;
      repeat (3) @(posedge CLK);
      chk({30'h0, PORT_B_DIGITAL}, 32'h1, "digital path a");
      PORT_B_IN <= 2'b10;
      repeat (3) @(posedge CLK);
      chk({30'h0, PORT_B_DIGITAL}, 32'h2, "digital path b");
   endtask

   // clock enable low mid-conversion must freeze everything
   task automatic t_hold();
      logic [31:0] snap;
      vin <= 10'h1b7;
      wr(OFS_CLOCK, 32'h0);
      wr(OFS_STATUS, {27'h0, CHAN_PORT_B_BIT_ONE});
      repeat (6) @(posedge CLK);
      CE <= 1'b0;
      @(posedge CLK);
      snap = {21'h0, SAMPLE_HOLD, DAC_CODE};
      repeat (10) @(posedge CLK);
      chk({21'h0, SAMPLE_HOLD, DAC_CODE}, snap, "frozen by enable");
      chk({31'h0, CONV_BUSY}, 32'h1, "busy while frozen");
      CE <= 1'b1;
      wait_done();
      apb(1'b0, OFS_RES_LO, 32'h0, q, e);
      chk(q, 32'hb7, "result after freeze");
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      // about 25k cycles, far beyond the few hundred the tests need
      #200_000;
      error_cnt++;
      results();
   end

   initial begin
      ARST_N = 1'b0;
      CE = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      STOP_MODE = 1'b0;
      PORT_B_IN = 2'b00;
      vin = 10'h000;
      error_cnt = 0;
      comparisons = 0;
      repeat (12) @(posedge CLK);
      ARST_N <= 1'b1;
      t_reset();
      t_conv(8'h00, CHAN_PORT_B_BIT_ZERO, 10'h2a5, 32'h2, 32'ha5, 4, 4);
      t_conv(8'h12, CHAN_PORT_B_BIT_ONE, 10'h05a, 32'h0, 32'h5a, 16, 16);
      t_conv(8'h01, CHAN_BANDGAP, 10'h3c3, 32'h3, 32'hc3, 16, 20);
      STOP_MODE <= 1'b1;
      t_conv(8'h80, CHAN_PORT_B_BIT_ZERO, 10'h0f0, 32'h0, 32'hf0, 16, 20);
      STOP_MODE <= 1'b0;
      t_freeze();
      t_chan();
      t_port();
      t_hold();
      results();
   end
endmodule
`default_nettype wire
